// ===== logic/boot_link_map.svh
// address map, byte codes and timing counts of the serial boot link
`ifndef BOOT_LINK_MAP_SVH
`define BOOT_LINK_MAP_SVH
`define FLASH_LO 16'hC000
`define FLASH_HI 16'hFFFF
`define PW_HI 16'hFF9F
`define PW_LIMIT 16'hFFA0
`define BLANK_LO 16'hFFE0
`define ERASED_BYTE 8'hFF
`define START_MARK 8'h3A
`define REC_DATA 8'h00
`define REC_END 8'h01
`define REC_EXT 8'h02
`define EXT_LEN 8'h02
`define END_LEN 8'h00
`define EXT_LIMIT 16'h1000
`define PW_MIN 8'h08
`define ID_COUNT 8'h0A
`define ID_ADDR_LEN 8'h02
`define ID_RSV0 8'h1D
`define ID_BLOCKS 8'h01
`define ST_COUNT 8'h04
`define ID_LEN 4'hD
`define ST_LEN 4'h7
`define SUM_LEN 4'h2
`define RESET_HOLD 4'h4
`endif

// ===== logic/boot_link_pkg.sv
// types shared by both ends of the serial boot link
package boot_link_pkg;
  typedef enum logic [2:0] {
    MODE_WRITE = 3'h0,
    MODE_RAM = 3'h1,
    MODE_SUM = 3'h2,
    MODE_ID = 3'h3,
    MODE_STATUS = 3'h4,
    MODE_ERASE = 3'h5
  } mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PTR = 4'h1,
    ST_BLANK = 4'h2,
    ST_COUNT = 4'h3,
    ST_PW = 4'h4,
    ST_MARK = 4'h5,
    ST_HDR = 4'h6,
    ST_DATA = 4'h7,
    ST_CSUM = 4'h8,
    ST_SCAN = 4'h9,
    ST_SEND = 4'hA,
    ST_HALT = 4'hB
  } dev_state_t;
endpackage

// ===== logic/boot_link_if.sv
// byte-level serial boot link between programming controller and device
interface boot_link_if;
  logic h2d_valid;
  logic [7:0] h2d_data;
  logic h2d_ready;
  logic d2h_valid;
  logic [7:0] d2h_data;
  logic d2h_ready;
  logic dev_reset_n;
  modport dev (input h2d_valid, input h2d_data, output h2d_ready,
               output d2h_valid, output d2h_data, input d2h_ready);
  modport host (output h2d_valid, output h2d_data, input h2d_ready,
                input d2h_valid, input d2h_data, output d2h_ready, output dev_reset_n);
endinterface

// ===== logic/sum_acc.sv
// 16-bit running byte sum
module sum_acc (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic add,
  input wire logic [7:0] byte_in,
  output logic [15:0] sum
);
  // one byte per cycle, carry kept to 16 bits; clear wins over add
  always_ff @(posedge ref_clk) begin
    if (!rstn || clr) begin
      sum <= 16'h0000;
    end else if (add) begin
      sum <= sum + {8'h00, byte_in};
    end
  end
endmodule

// ===== logic/boot_device.sv
// device end: password check, hex record parser, checksums, id and status replies
// Contract
// - write/sum modes sum whole flash from C000H
// - only record payload bytes enter sums
// - RAM mode sums received RAM bytes
// - id/status checksums cover their payload bytes
// - erase sums erased sectors or whole chip
// - after record checksum, wait for 3AH
// - host sends nothing after end record
// - receive or format error halts silently
// - record type beyond 00H..02H halts
// - bad record checksum halts
// - extended record length must be 02H
// - data after extended address >=1000H halts
// - end record length must be 00H
// - password area C000H..FF9FH only
// - blank part skips compare, pointers still sent
// - non-blank needs N>=8, start<=FFA0-N
// - three identical consecutive password bytes halt
// - blank write/RAM takes hex right after pointers
// - no password string to blank erase
// - password mismatch halts; host resets device
// - id reply is fixed 13-byte frame
// - id last byte negates sum of bytes 3..12
// - checksum is 16-bit byte sum
module boot_device (
  input wire logic ref_clk,
  input wire logic rstn,
  boot_link_if.dev link,
  input wire logic cmd_valid,
  input wire boot_link_pkg::mode_t cmd_mode,
  output logic cmd_ready,
  input wire logic rx_fault,
  input wire logic erase_chip,
  input wire logic [15:0] erase_first,
  input wire logic [15:0] erase_last,
  input wire logic prot_on,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  output logic halted
);
  import boot_link_pkg::*;
`include "boot_link_map.svh"

  // ****************************************
  // state and working registers
  // ****************************************
  dev_state_t state_reg;
  mode_t mode_reg;
  logic [15:0] addr_reg, end_reg, password_count_location_reg, password_compare_start_reg, raddr_reg, ext_reg;
  logic [7:0] cnt_reg, len_reg, type_reg, rsum_reg, prev_reg, tx_data_reg;
  logic [3:0] tx_idx_reg;
  logic run_reg, blank_reg, ext_bad_reg, tx_valid_reg;
  logic rx, tx_done, blank_now, acc_clr, acc_add;
  logic [7:0] acc_byte, tx_byte, rx_byte;
  logic [15:0] sum;
  logic [3:0] tx_len;

  assign rx_byte = link.h2d_data;
  assign rx = link.h2d_valid && link.h2d_ready;
  assign tx_done = link.d2h_valid && link.d2h_ready;
  assign blank_now = blank_reg && (flash_rdata == `ERASED_BYTE);
  assign flash_addr = addr_reg;
  assign cmd_ready = (state_reg == ST_IDLE);
  assign halted = (state_reg == ST_HALT);
  assign link.d2h_valid = tx_valid_reg;
  assign link.d2h_data = tx_data_reg;
  // a halted device keeps swallowing bytes so the host never stalls on it
  assign link.h2d_ready = (state_reg inside {ST_PTR, ST_PW, ST_MARK, ST_HDR, ST_DATA,
                                             ST_CSUM, ST_HALT});
  assign tx_len = (mode_reg == MODE_ID) ? `ID_LEN :
                  (mode_reg == MODE_STATUS) ? `ST_LEN : `SUM_LEN;

  // ****************************************
  // reply byte selection
  // ****************************************
  always_comb begin
    tx_byte = 8'h00;
    if (mode_reg == MODE_ID) begin
      unique case (tx_idx_reg)
        4'h0: tx_byte = `START_MARK;
        4'h1: tx_byte = `ID_COUNT;
        4'h2: tx_byte = `ID_ADDR_LEN;
        4'h3: tx_byte = `ID_RSV0;
        4'h7: tx_byte = `ID_BLOCKS;
        4'h8: tx_byte = 8'(`FLASH_LO >> 8);
        4'h9: tx_byte = 8'(`FLASH_LO & 16'h00FF);
        4'hA: tx_byte = 8'(`FLASH_HI >> 8);
        4'hB: tx_byte = 8'(`FLASH_HI & 16'h00FF);
        4'hC: tx_byte = 8'h00 - sum[7:0];
        default: tx_byte = 8'h00;
      endcase
    end else if (mode_reg == MODE_STATUS) begin
      unique case (tx_idx_reg)
        4'h0: tx_byte = `START_MARK;
        4'h1: tx_byte = `ST_COUNT;
        4'h2: tx_byte = {6'h00, prot_on, ~blank_reg};
        4'h6: tx_byte = 8'h00 - sum[7:0];
        default: tx_byte = 8'h00;
      endcase
    end else begin
      tx_byte = (tx_idx_reg == 4'h0) ? sum[15:8] : sum[7:0];
    end
  end

  // ****************************************
  // checksum feed
  // ****************************************
  // header and record checksum bytes never reach the accumulator
  always_comb begin
    acc_add = 1'b0;
    acc_byte = flash_rdata;
    if (state_reg == ST_SCAN) begin
      acc_add = 1'b1;
    end else if (state_reg == ST_DATA && rx) begin
      acc_byte = rx_byte;
      acc_add = (mode_reg == MODE_RAM) && (type_reg == `REC_DATA);
    end else if (state_reg == ST_SEND && !tx_valid_reg && mode_reg != MODE_SUM) begin
      acc_byte = tx_byte;
      acc_add = (tx_idx_reg >= 4'h2) && (tx_idx_reg < tx_len - 4'h1);
    end
  end
  assign acc_clr = (state_reg == ST_IDLE);

  sum_acc u_acc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clr(acc_clr),
    .add(acc_add),
    .byte_in(acc_byte),
    .sum(sum)
  );

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_WRITE;
      addr_reg <= 16'h0000;
      end_reg <= 16'h0000;
      cnt_reg <= 8'h00;
      blank_reg <= 1'b1;
    end else if (rx_fault && link.h2d_ready && state_reg != ST_HALT) begin
      state_reg <= ST_HALT;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (cmd_valid) begin
          mode_reg <= cmd_mode;
          cnt_reg <= 8'h00;
          blank_reg <= 1'b1;
          addr_reg <= (cmd_mode == MODE_STATUS) ? `BLANK_LO : `FLASH_LO;
          end_reg <= `FLASH_HI;
          unique case (cmd_mode)
            MODE_SUM: state_reg <= ST_SCAN;
            MODE_ID: state_reg <= ST_SEND;
            MODE_STATUS: state_reg <= ST_BLANK;
            default: state_reg <= ST_PTR;
          endcase
        end
        ST_PTR: if (rx) begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'h03) begin
            addr_reg <= `BLANK_LO;
            // both pointers must fall in the password area
            if (password_count_location_reg < `FLASH_LO || password_count_location_reg > `PW_HI
                || {password_compare_start_reg[7:0], rx_byte} < `FLASH_LO
                || {password_compare_start_reg[7:0], rx_byte} > `PW_HI) begin
              state_reg <= ST_HALT;
            end else begin
              state_reg <= ST_BLANK;
            end
          end
        end
        ST_BLANK: begin
          blank_reg <= blank_now;
          addr_reg <= addr_reg + 16'h0001;
          if (addr_reg == `FLASH_HI) begin
            if (mode_reg == MODE_STATUS) begin
              state_reg <= ST_SEND;
            end else if (!blank_now) begin
              addr_reg <= password_count_location_reg;
              state_reg <= ST_COUNT;
            end else if (mode_reg == MODE_ERASE) begin
              addr_reg <= erase_chip ? `FLASH_LO : erase_first;
              end_reg <= erase_chip ? `FLASH_HI : erase_last;
              state_reg <= ST_SCAN;
            end else begin
              state_reg <= ST_MARK;
            end
          end
        end
        ST_COUNT: begin
          cnt_reg <= flash_rdata;
          addr_reg <= password_compare_start_reg;
          if (flash_rdata < `PW_MIN || password_compare_start_reg > `PW_LIMIT - {8'h00, flash_rdata}) begin
            state_reg <= ST_HALT;
          end else begin
            state_reg <= ST_PW;
          end
        end
        ST_PW: if (rx) begin
          addr_reg <= addr_reg + 16'h0001;
          cnt_reg <= cnt_reg - 8'h01;
          if (rx_byte != flash_rdata) begin
            state_reg <= ST_HALT;
          end else if (run_reg && rx_byte == prev_reg && addr_reg != password_compare_start_reg) begin
            state_reg <= ST_HALT;
          end else if (cnt_reg == 8'h01) begin
            if (mode_reg == MODE_ERASE) begin
              addr_reg <= erase_chip ? `FLASH_LO : erase_first;
              end_reg <= erase_chip ? `FLASH_HI : erase_last;
              state_reg <= ST_SCAN;
            end else begin
              state_reg <= ST_MARK;
            end
          end
        end
        ST_MARK: if (rx && rx_byte == `START_MARK) begin
          cnt_reg <= 8'h00;
          state_reg <= ST_HDR;
        end
        ST_HDR: if (rx) begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'h03) begin
            cnt_reg <= len_reg;
            if (rx_byte > `REC_EXT) begin
              state_reg <= ST_HALT;
            end else if (rx_byte == `REC_EXT && len_reg != `EXT_LEN) begin
              state_reg <= ST_HALT;
            end else if (rx_byte == `REC_END && len_reg != `END_LEN) begin
              state_reg <= ST_HALT;
            end else if (rx_byte == `REC_DATA && ext_bad_reg) begin
              state_reg <= ST_HALT;
            end else if (len_reg == 8'h00) begin
              state_reg <= ST_CSUM;
            end else begin
              state_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: if (rx) begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_reg == 8'h01) begin
            state_reg <= ST_CSUM;
          end
        end
        ST_CSUM: if (rx) begin
          if (rsum_reg + rx_byte != 8'h00) begin
            state_reg <= ST_HALT;
          end else if (type_reg == `REC_END && mode_reg == MODE_WRITE) begin
            addr_reg <= `FLASH_LO;
            end_reg <= `FLASH_HI;
            state_reg <= ST_SCAN;
          end else if (type_reg == `REC_END) begin
            state_reg <= ST_SEND;
          end else begin
            state_reg <= ST_MARK;
          end
        end
        ST_SCAN: begin
          addr_reg <= addr_reg + 16'h0001;
          if (addr_reg == end_reg) begin
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: if (tx_done && tx_idx_reg == tx_len - 4'h1) begin
          state_reg <= ST_IDLE;
        end
        ST_HALT: state_reg <= ST_HALT;
        default: state_reg <= ST_HALT;
      endcase
    end
  end

  // ****************************************
  // pointer capture and password run tracking
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      password_count_location_reg <= 16'h0000;
      password_compare_start_reg <= 16'h0000;
      prev_reg <= 8'h00;
      run_reg <= 1'b0;
    end else if (state_reg == ST_PTR && rx) begin
      run_reg <= 1'b0;
      if (cnt_reg < 8'h02) begin
        password_count_location_reg <= {password_count_location_reg[7:0], rx_byte};
      end else begin
        password_compare_start_reg <= {password_compare_start_reg[7:0], rx_byte};
      end
    end else if (state_reg == ST_PW && rx) begin
      // run_reg marks two equal bytes in a row; a third match halts
      run_reg <= (addr_reg != password_compare_start_reg) && (rx_byte == prev_reg);
      prev_reg <= rx_byte;
    end
  end

  // ****************************************
  // record fields, record checksum and writes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      len_reg <= 8'h00;
      type_reg <= 8'h00;
      raddr_reg <= 16'h0000;
      ext_reg <= 16'h0000;
      rsum_reg <= 8'h00;
      ext_bad_reg <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 8'h00;
    end else begin
      wr_valid <= 1'b0;
      if (state_reg == ST_IDLE) begin
        ext_bad_reg <= 1'b0;
      end
      if (state_reg == ST_MARK) begin
        rsum_reg <= 8'h00;
      end else if (rx && (state_reg == ST_HDR || state_reg == ST_DATA)) begin
        rsum_reg <= rsum_reg + rx_byte;
      end
      if (state_reg == ST_HDR && rx) begin
        unique case (cnt_reg[1:0])
          2'h0: len_reg <= rx_byte;
          2'h1: raddr_reg[15:8] <= rx_byte;
          2'h2: raddr_reg[7:0] <= rx_byte;
          2'h3: type_reg <= rx_byte;
        endcase
      end
      if (state_reg == ST_DATA && rx) begin
        if (type_reg == `REC_DATA) begin
          wr_valid <= 1'b1;
          wr_addr <= raddr_reg;
          wr_data <= rx_byte;
          raddr_reg <= raddr_reg + 16'h0001;
        end else if (type_reg == `REC_EXT) begin
          ext_reg <= {ext_reg[7:0], rx_byte};
        end
      end
      if (state_reg == ST_CSUM && rx && type_reg == `REC_EXT) begin
        ext_bad_reg <= (ext_reg >= `EXT_LIMIT);
      end
    end
  end

  // ****************************************
  // reply transmitter
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_idx_reg <= 4'h0;
    end else if (state_reg != ST_SEND) begin
      tx_valid_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
    end else if (!tx_valid_reg) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= tx_byte;
    end else if (tx_done) begin
      tx_valid_reg <= 1'b0;
      tx_idx_reg <= tx_idx_reg + 4'h1;
    end
  end
endmodule

// ===== logic/boot_host.sv
// programming controller end: byte sender with end-record hold-off and device reset
module boot_host (
  input wire logic ref_clk,
  input wire logic rstn,
  boot_link_if.host link,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic hex_phase,
  input wire logic pw_skip,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic restart
);
  import boot_link_pkg::*;
`include "boot_link_map.svh"

  // ****************************************
  // outgoing bytes and record tracking
  // ****************************************
  logic h2d_valid_reg, block_reg, end_rec_reg;
  logic [7:0] h2d_data_reg, left_reg;
  logic [2:0] fld_reg;
  logic [1:0] wait_reg;
  logic [3:0] rst_cnt_reg;
  logic take;

  assign link.h2d_valid = h2d_valid_reg;
  assign link.h2d_data = h2d_data_reg;
  assign link.d2h_ready = 1'b1;
  assign link.dev_reset_n = (rst_cnt_reg == 4'h0);
  assign tx_ready = !h2d_valid_reg && !block_reg;
  assign take = tx_valid && tx_ready;

  // a dropped byte never reaches the link: blank erase gets no password string
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      h2d_valid_reg <= 1'b0;
      h2d_data_reg <= 8'h00;
    end else if (take) begin
      h2d_valid_reg <= !pw_skip;
      h2d_data_reg <= tx_data;
    end else if (link.h2d_ready) begin
      h2d_valid_reg <= 1'b0;
    end
  end

  // fld: 0 mark, 1 length, 2..4 address and type, 5 payload, 6 checksum
  always_ff @(posedge ref_clk) begin
    if (!rstn || !hex_phase) begin
      fld_reg <= 3'h0;
      left_reg <= 8'h00;
      end_rec_reg <= 1'b0;
      block_reg <= 1'b0;
      wait_reg <= 2'h0;
    end else if (block_reg) begin
      // after the end record only the two checksum bytes may move
      if (link.d2h_valid) begin
        wait_reg <= wait_reg + 2'h1;
        block_reg <= (wait_reg == 2'h0);
      end
    end else if (take) begin
      unique case (fld_reg)
        3'h0: fld_reg <= (tx_data == `START_MARK) ? 3'h1 : 3'h0;
        3'h1: begin
          left_reg <= tx_data;
          fld_reg <= 3'h2;
        end
        3'h4: begin
          end_rec_reg <= (tx_data == `REC_END);
          fld_reg <= (left_reg == 8'h00) ? 3'h6 : 3'h5;
        end
        3'h5: begin
          left_reg <= left_reg - 8'h01;
          fld_reg <= (left_reg == 8'h01) ? 3'h6 : 3'h5;
        end
        3'h6: begin
          fld_reg <= 3'h0;
          block_reg <= end_rec_reg;
        end
        default: fld_reg <= fld_reg + 3'h1;
      endcase
    end
  end

  // ****************************************
  // incoming bytes and device reset pulse
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= link.d2h_valid;
      if (link.d2h_valid) begin
        rx_data <= link.d2h_data;
      end
    end
  end

  // a halted device only recovers through its reset pin
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rst_cnt_reg <= 4'h0;
    end else if (restart) begin
      rst_cnt_reg <= `RESET_HOLD;
    end else if (rst_cnt_reg != 4'h0) begin
      rst_cnt_reg <= rst_cnt_reg - 4'h1;
    end
  end
endmodule

// ===== verification/boot_link_monitor.sv
// checker watching the byte link between the controller and device ends
`include "boot_link_map.svh"
module boot_link_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_ready,
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_ready,
  input wire logic dev_reset_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic take;
  logic [7:0] prev_reg;
  assign take = d2h_valid & d2h_ready;
  // last reply byte taken, so fields can be found by what preceded them
  always_ff @(posedge ref_clk) begin
    if (!rstn) prev_reg <= 8'h00;
    else if (take) prev_reg <= d2h_data;
  end
  // ****************************************
  // assertions
  // ****************************************
  chk_dev_reset_quiet: assert property (!dev_reset_n |=> !d2h_valid && !h2d_ready)
    else $error("device still active after reset pin");
  chk_listen_silent: assert property (h2d_ready |-> !d2h_valid)
    else $error("device sends while listening or halted");
  chk_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("controller byte changed before taken");
  chk_d2h_gap: assert property (take |=> !d2h_valid)
    else $error("reply byte reloaded too early");
  chk_id_addrlen: assert property (take && prev_reg == `START_MARK && d2h_data == `ID_COUNT
    |-> ##2 take && d2h_data == `ID_ADDR_LEN)
    else $error("id reply address length wrong");
  chk_id_tail: assert property (take && prev_reg == `ID_BLOCKS && d2h_data == 8'hC0
    |-> ##2 (take && d2h_data == 8'h00) ##2 (take && d2h_data == 8'hFF)
    ##2 (take && d2h_data == 8'hFF) ##2 (take && d2h_data == 8'h22))
    else $error("id reply range or checksum wrong");
  chk_status_frame: assert property (take && prev_reg == `START_MARK && d2h_data == `ST_COUNT
    |-> ##4 (take && d2h_data == 8'h00) ##2 (take && d2h_data == 8'h00)
    ##2 (take && d2h_data == 8'h00)
    ##2 (take && d2h_data == 8'(8'h00 - $past(d2h_data, 8))))
    else $error("status reply frame or checksum wrong");
  chk_reset_pulse: assert property ($fell(dev_reset_n) |-> !dev_reset_n [*4])
    else $error("device reset pulse too short");
endmodule

// ===== verification/tb.sv
// self-checking bench joining both ends of the serial boot link
`include "boot_link_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import boot_link_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, prot_on = 1'b0, tx_valid = 1'b0;
  logic hex_phase = 1'b0, restart = 1'b0, dev_rstn, cmd_ready, wr_valid, halted;
  logic tx_ready, rx_valid;
  logic [7:0] tx_data = 8'h00, flash_rdata, wr_data, rx_data;
  logic [15:0] flash_addr, wr_addr;
  mode_t cmd_mode = MODE_WRITE;
  int errors = 0, total_checks = 0, cycles = 0;
  logic [7:0] rx_q [$];
  logic [7:0] flash [0:65535];
  boot_link_if link ();
  // device reset pin and bench reset both clear the device end
  assign dev_rstn = rstn & link.dev_reset_n;
  assign flash_rdata = flash[flash_addr];
  boot_device boot_device_i (.ref_clk(ref_clk), .rstn(dev_rstn), .link(link.dev),
    .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_ready(cmd_ready), .rx_fault(1'b0),
    .erase_chip(1'b0), .erase_first(16'hC000), .erase_last(16'hCFFF), .prot_on(prot_on),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .halted(halted));
  boot_host boot_host_i (.ref_clk(ref_clk), .rstn(rstn), .link(link.host), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .hex_phase(hex_phase), .pw_skip(1'b0),
    .rx_valid(rx_valid), .rx_data(rx_data), .restart(restart));
  boot_link_monitor boot_link_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
    .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data), .h2d_ready(link.h2d_ready),
    .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data), .d2h_ready(link.d2h_ready),
    .dev_reset_n(link.dev_reset_n));
  // clock, flash model that takes the payload writes, reply collector, hang limit
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1) flash[wr_addr] <= wr_data;
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("MISMATCH run length expected done seen running");
      end_sim();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one edge always passes first, so tx_valid is never set twice in one step
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge ref_clk) #1;
    while (tx_ready !== 1'b1 && n < 20000) begin
      @(posedge ref_clk) #1;
      n++;
    end
    tx_valid = 1'b1;
    tx_data = b;
    @(posedge ref_clk) #1;
    tx_valid = 1'b0;
  endtask
  task automatic send_all(input logic [7:0] q [$]);
    foreach (q[i]) send(q[i]);
  endtask
  task automatic get(input string name, input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(name, exp, (rx_q.size() > 0) ? rx_q.pop_front() : 8'hxx);
  endtask
  task automatic cmd(input mode_t m);
    @(posedge ref_clk) #1;
    chk("cmd_ready", 8'h01, {7'h00, cmd_ready});
    cmd_valid = 1'b1;
    cmd_mode = m;
    @(posedge ref_clk) #1;
    cmd_valid = 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_id();
    logic [7:0] e [13];
    e = '{8'h3A, 8'h0A, 8'h02, 8'h1D, 8'h00, 8'h00, 8'h00, 8'h01, 8'hC0, 8'h00, 8'hFF, 8'hFF,
          8'h22};
    cmd(MODE_ID);
    foreach (e[i]) get("id reply byte", e[i]);
  endtask
  // blank part with protection on gives code 02h and checksum FEh
  task automatic test_status();
    logic [7:0] e [7];
    e = '{8'h3A, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'hFE};
    prot_on = 1'b1;
    cmd(MODE_STATUS);
    foreach (e[i]) get("status reply byte", e[i]);
  endtask
  // sum covers every flash byte, only two of which the record changed
  task automatic test_write();
    logic [15:0] s;
    s = 16'(32'h4000 * 32'hFF - 32'h2 * 32'hFF + 32'h12 + 32'h34);
    cmd(MODE_WRITE);
    send_all('{8'hF0, 8'h00, 8'hF0, 8'h01, 8'h55});
    hex_phase = 1'b1;
    send_all('{8'h3A, 8'h02, 8'hC0, 8'h00, 8'h00, 8'h12, 8'h34, 8'hF8, 8'hAA});
    send_all('{8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF});
    get("sum upper", s[15:8]);
    get("sum lower", s[7:0]);
    chk("flash C000", 8'h12, flash[16'hC000]);
    hex_phase = 1'b0;
  endtask
  // bad type, bad checksum, bad extended length, bad end length
  task automatic test_halts();
    logic [7:0] t [4][7];
    t = '{'{8'h3A, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'hFC},
          '{8'h3A, 8'h01, 8'hC0, 8'h00, 8'h00, 8'h55, 8'h00},
          '{8'h3A, 8'h01, 8'h00, 8'h00, 8'h02, 8'h10, 8'hED},
          '{8'h3A, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFE}};
    for (int k = 0; k < 4; k++) begin
      cmd(MODE_RAM);
      send_all('{8'hF0, 8'h00, 8'hF0, 8'h01});
      for (int j = 0; j < 7; j++) send(t[k][j]);
      send(8'h3A);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("halted", 8'h01, {7'h00, halted});
      chk("bytes sent", 8'h00, 8'(rx_q.size()));
      restart = 1'b1;
      @(posedge ref_clk) #1;
      restart = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("halted after reset", 8'h00, {7'h00, halted});
    end
  endtask
  // non-blank part: eight-byte password, then one RAM record summed
  task automatic test_password();
    logic [7:0] pw [8];
    pw = '{8'h43, 8'h4F, 8'h44, 8'h45, 8'h31, 8'h32, 8'h33, 8'h34};
    flash[16'hFFFF] = 8'h00;
    flash[16'hF000] = 8'h08;
    foreach (pw[i]) flash[16'hF001 + i] = pw[i];
    cmd(MODE_RAM);
    send_all('{8'hF0, 8'h00, 8'hF0, 8'h01});
    foreach (pw[i]) send(pw[i]);
    hex_phase = 1'b1;
    send_all('{8'h3A, 8'h01, 8'h00, 8'h10, 8'h00, 8'h5A, 8'h95});
    send_all('{8'h3A, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF});
    get("ram sum upper", 8'h00);
    get("ram sum lower", 8'h5A);
    chk("halted after password", 8'h00, {7'h00, halted});
    hex_phase = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (int a = 0; a < 65536; a++) flash[a] = 8'hFF;
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    test_id();
    test_status();
    test_write();
    test_halts();
    test_password();
    end_sim();
  end
endmodule
